// ### lfr_pkg.sv
// Purpose: constants and carriers for the lookup-table function, memory and shift cell
// Assumes: one logic tile of four memory-capable and four logic-only tables
// Notes: register offsets are word indices on the plain configuration port
// Behaviour
// RULE1 - each table maps its four select inputs to one output, any Boolean function
// RULE2 - combining multiplexers join tables here or in adjacent tiles for wider functions
// RULE3 - every table can serve as ROM holding its configuration-loaded contents
// RULE4 - only left tables 0..3 offer memory and shift modes; right tables logic only
// RULE5 - memory mode gives 16 writable bits per left table, addressed by its selects
// RULE6 - left tables combine into wider or deeper memories
// RULE7 - dual-port option pairs two tables with independent read address paths
// RULE8 - memory contents can be preloaded at configuration before any user write
// RULE9 - shift mode: 16-bit shift register with tap giving 1 to 16 cycles delay
// RULE10 - four left tables chain into one shift register of up to 64 stages
// RULE11 - cascade input and output carry the end bit between chained shift registers
// RULE12 - writes and shifts only on clock edge with write enable; reads combinational
package lfr_pkg;
  localparam int LFR_LUT_BITS = 16;
  localparam int LFR_NUM_LUT = 8;
  localparam int LFR_NUM_LEFT = 4;
  localparam int LFR_ADDR_W = 4;
  localparam int LFR_DATA_W = 16;
  // register indices
  localparam logic [3:0] LFR_ADDR_INIT0 = 4'h0;
  localparam logic [3:0] LFR_ADDR_MODE = 4'h8;
  localparam logic [3:0] LFR_ADDR_TAP = 4'h9;
  localparam logic [3:0] LFR_ADDR_CTRL = 4'ha;
  localparam logic [3:0] LFR_ADDR_STAT = 4'hb;
  // field positions
  localparam int LFR_MODE_W = 2;
  localparam int LFR_DUAL_POS = 8;
  localparam int LFR_CHAIN_POS = 0;
  localparam int LFR_DEPTH_POS = 1;
  localparam int LFR_TAP_W = 4;
  // per-table mode codes
  localparam logic [1:0] LFR_MODE_LOGIC = 2'h0;
  localparam logic [1:0] LFR_MODE_RAM = 2'h1;
  localparam logic [1:0] LFR_MODE_SRL = 2'h2;
  // reset values
  localparam logic [15:0] LFR_LUT_RST = 16'h0000;
  localparam logic [9:0] LFR_MODE_RST = 10'h000;
  localparam logic [15:0] LFR_TAP_RST = 16'h0000;
  localparam logic [1:0] LFR_CTRL_RST = 2'h0;

  typedef enum logic [2:0] {
    LFR_BUF_EMPTY = 3'b001,
    LFR_BUF_ONE = 3'b010,
    LFR_BUF_FULL = 3'b100
  } lfr_buf_t;

  // one user beat into the tile
  typedef struct packed {
    logic [7:0][3:0] table_select_inputs;
    logic [3:0] wdata;
    logic we;
    logic cascade_in;
    logic [3:0] wide_sel;
    logic wide_in;
    logic [1:0] bank;
  } lfr_beat_t;

  // one result out of the tile
  typedef struct packed {
    logic [7:0] lut;
    logic wide;
    logic cascade_out;
  } lfr_res_t;
endpackage

// ### lfr_cell.sv
// Purpose: one logic tile of lookup tables usable as logic, ROM, distributed RAM or shift register
// Assumes: user beats arrive on the fabric clock with valid/ready; config port on same clock
// Notes: results pass a two-entry buffer, so outputs lag the combinational read by a cycle
`timescale 1ns/1ps
module lfr_cell (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // configuration port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // user beat in
  input wire logic i_valid,
  input wire lfr_pkg::lfr_beat_t i_beat,
  output logic o_ready,
  // result out
  output logic o_valid,
  output lfr_pkg::lfr_res_t o_res,
  input wire logic i_ready
);

  logic [15:0] lut [8];
  logic [15:0] next_lut [8];
  logic [9:0] mode;
  logic [9:0] next_mode;
  logic [15:0] tap;
  logic [15:0] next_tap;
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [15:0] next_rdata;
  lfr_pkg::lfr_buf_t buf_state;
  lfr_pkg::lfr_buf_t next_buf_state;
  lfr_pkg::lfr_res_t ent1;
  lfr_pkg::lfr_res_t next_ent1;
  lfr_pkg::lfr_res_t next_res;
  logic next_valid;
  logic next_ready;
  lfr_pkg::lfr_res_t res;
  logic accept;
  logic pop;

  function automatic logic lut_read(input logic [15:0] word, input logic [3:0] sel);
    lut_read = word[sel];
  endfunction

  function automatic logic [1:0] mode_of(input logic [9:0] m, input int k);
    mode_of = m[k*lfr_pkg::LFR_MODE_W +: lfr_pkg::LFR_MODE_W];
  endfunction

  assign accept = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // combinational read of every table
  always_comb begin
    res = '0;
    for (int k = 0; k < lfr_pkg::LFR_NUM_LUT; k++) begin
      if (k < lfr_pkg::LFR_NUM_LEFT && mode_of(mode, k) == lfr_pkg::LFR_MODE_SRL) begin
        res.lut[k] = lut_read(lut[k], tap[k*lfr_pkg::LFR_TAP_W +: lfr_pkg::LFR_TAP_W]); // RULE9 RULE12
      end else begin
        // port B of a dual pair reads the odd table at its own selects
        res.lut[k] = lut_read(lut[k], i_beat.table_select_inputs[k]); // RULE1 RULE3 RULE7 RULE12
      end
    end
    if (i_beat.wide_sel[3]) begin
      res.wide = i_beat.wide_in; // RULE2
    end else begin
      res.wide = res.lut[i_beat.wide_sel[2:0]]; // RULE2 RULE6
    end
    res.cascade_out = lut[3][15]; // RULE11
  end

  // table storage: user writes and shifts, config port loads
  always_comb begin
    logic [1:0] md;
    logic pair_b;
    logic [3:0] wa;
    logic wd;
    logic sin;
    logic depth_ok;
    md = '0;
    pair_b = 1'b0;
    wa = '0;
    wd = 1'b0;
    sin = 1'b0;
    depth_ok = 1'b0;
    for (int k = 0; k < lfr_pkg::LFR_NUM_LUT; k++) begin
      next_lut[k] = lut[k];
    end
    // only the left tables ever take user writes
    for (int k = 0; k < lfr_pkg::LFR_NUM_LEFT; k++) begin // RULE4
      md = mode_of(mode, k);
      pair_b = mode[lfr_pkg::LFR_DUAL_POS + k/2] && (k % 2 == 1);
      if (pair_b) begin
        wa = i_beat.table_select_inputs[k-1]; // RULE7
        wd = i_beat.wdata[k-1];
      end else begin
        wa = i_beat.table_select_inputs[k];
        wd = i_beat.wdata[k];
      end
      // deep mode: bank picks the table written (a dual partner writes with it); else all write in parallel
      depth_ok = !ctrl[lfr_pkg::LFR_DEPTH_POS] || (i_beat.bank == 2'(k)) || pair_b; // RULE6
      if (pair_b && ctrl[lfr_pkg::LFR_DEPTH_POS]) begin
        depth_ok = (i_beat.bank == 2'(k-1));
      end
      if (k == 0) begin
        sin = ctrl[lfr_pkg::LFR_CHAIN_POS] ? i_beat.cascade_in : i_beat.wdata[0]; // RULE11
      end else begin
        sin = ctrl[lfr_pkg::LFR_CHAIN_POS] ? lut[k-1][15] : i_beat.wdata[k]; // RULE10
      end
      if (accept && i_beat.we) begin // RULE12
        if (md == lfr_pkg::LFR_MODE_RAM && depth_ok) begin
          next_lut[k][wa] = wd; // RULE5
        end else if (md == lfr_pkg::LFR_MODE_SRL) begin
          next_lut[k] = {lut[k][14:0], sin}; // RULE9
        end
      end
    end
    // config load wins over a user write in the same cycle
    if (i_wr && !i_addr[3]) begin
      next_lut[i_addr[2:0]] = i_wdata; // RULE3 RULE8
    end
  end

  // control registers and read-back
  always_comb begin
    next_mode = mode;
    next_tap = tap;
    next_ctrl = ctrl;
    next_rdata = 16'h0000;
    if (i_wr) begin
      case (i_addr)
        lfr_pkg::LFR_ADDR_MODE: next_mode = i_wdata[9:0];
        lfr_pkg::LFR_ADDR_TAP: next_tap = i_wdata;
        lfr_pkg::LFR_ADDR_CTRL: next_ctrl = i_wdata[1:0];
        default: next_mode = mode;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        lfr_pkg::LFR_ADDR_MODE: next_rdata = {6'h00, mode};
        lfr_pkg::LFR_ADDR_TAP: next_rdata = tap;
        lfr_pkg::LFR_ADDR_CTRL: next_rdata = {14'h0000, ctrl};
        lfr_pkg::LFR_ADDR_STAT: next_rdata = {11'h000, buf_state, o_ready, lut[3][15]};
        default: begin
          if (!i_addr[3]) begin
            next_rdata = lut[i_addr[2:0]];
          end
        end
      endcase
    end
  end

  // two-entry result buffer; full stalls user beats
  always_comb begin
    next_buf_state = buf_state;
    next_res = o_res;
    next_ent1 = ent1;
    case (buf_state)
      lfr_pkg::LFR_BUF_EMPTY: begin
        if (accept) begin
          next_res = res;
          next_buf_state = lfr_pkg::LFR_BUF_ONE;
        end
      end
      lfr_pkg::LFR_BUF_ONE: begin
        if (accept && pop) begin
          next_res = res;
        end else if (accept) begin
          next_ent1 = res;
          next_buf_state = lfr_pkg::LFR_BUF_FULL;
        end else if (pop) begin
          next_buf_state = lfr_pkg::LFR_BUF_EMPTY;
        end
      end
      lfr_pkg::LFR_BUF_FULL: begin
        if (pop) begin
          next_res = ent1;
          next_buf_state = lfr_pkg::LFR_BUF_ONE;
        end
      end
      default: next_buf_state = lfr_pkg::LFR_BUF_EMPTY;
    endcase
    next_valid = (next_buf_state != lfr_pkg::LFR_BUF_EMPTY);
    next_ready = (next_buf_state != lfr_pkg::LFR_BUF_FULL);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int k = 0; k < lfr_pkg::LFR_NUM_LUT; k++) begin
        lut[k] <= lfr_pkg::LFR_LUT_RST;
      end
      mode <= lfr_pkg::LFR_MODE_RST;
      tap <= lfr_pkg::LFR_TAP_RST;
      ctrl <= lfr_pkg::LFR_CTRL_RST;
      o_rdata <= 16'h0000;
      buf_state <= lfr_pkg::LFR_BUF_EMPTY;
      o_res <= '0;
      ent1 <= '0;
      o_valid <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      for (int k = 0; k < lfr_pkg::LFR_NUM_LUT; k++) begin
        lut[k] <= next_lut[k];
      end
      mode <= next_mode;
      tap <= next_tap;
      ctrl <= next_ctrl;
      o_rdata <= next_rdata;
      buf_state <= next_buf_state;
      o_res <= next_res;
      ent1 <= next_ent1;
      o_valid <= next_valid;
      o_ready <= next_ready;
    end
  end

endmodule

// ### lfr_cell_properties.sv
// Purpose: port-level checks for the lookup-table tile
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the top-level ports
`timescale 1ns/1ps
module lfr_cell_props (
  // clock, reset and config port
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // user stream
  input wire logic i_valid,
  input wire lfr_pkg::lfr_beat_t i_beat,
  input wire logic o_ready,
  input wire logic o_valid,
  input wire lfr_pkg::lfr_res_t o_res,
  input wire logic i_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data without strobe");
  a_rdata_hole: assert property (i_rd && i_addr >= 4'hc |=> o_rdata == 16'h0000) else $error("unmapped read");
  a_ready_release: assert property ($rose(i_nrst) |=> o_ready) else $error("not ready after reset");
  a_hold_stall: assert property (o_valid && !i_ready |=> o_valid && $stable(o_res)) else $error("result moved");
  a_fall_popped: assert property ($fell(o_valid) |-> $past(i_ready)) else $error("result dropped");
  a_full_refuse: assert property (o_valid && !i_ready && i_valid && o_ready |=> !o_ready) else $error("no refuse");
  a_accept_valid: assert property (i_valid && o_ready |=> o_valid) else $error("beat lost");
  a_busy_full: assert property ($past(i_nrst) && !o_ready |-> o_valid) else $error("refused while empty");
  a_wide_pass: assert property (i_valid && o_ready && (!o_valid || i_ready) && i_beat.wide_sel[3]
    |=> o_res.wide == $past(i_beat.wide_in)) else $error("wide input not passed");
  c_full: cover property (o_valid && !o_ready);
  c_wide: cover property (i_valid && o_ready && i_beat.wide_sel[3]);
  c_read: cover property (i_rd && i_addr == lfr_pkg::LFR_ADDR_MODE);
endmodule
bind lfr_cell lfr_cell_props u_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid), .i_beat(i_beat), .o_ready(o_ready),
  .o_valid(o_valid), .o_res(o_res), .i_ready(i_ready));

// ### lfr_sink.sv
// Purpose: fabric consumer of tile results
// Assumes: bench raises stall to hold results back
// Notes: collected results are read from got by the bench
`timescale 1ns/1ps
module lfr_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // result stream
  input wire logic i_valid,
  input wire lfr_pkg::lfr_res_t i_res,
  output logic o_ready = 1'b0,
  input wire logic i_stall
);
  lfr_pkg::lfr_res_t got[$];
  always @(posedge i_clk) begin
    if (i_nrst && i_valid && o_ready) got.push_back(i_res);
    o_ready <= i_nrst && !i_stall;
  end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the lookup-table tile
// Assumes: 100 MHz clock, bench tasks entered at a rising edge and drive by non-blocking assignment
// Notes: one scenario per task
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_valid = 1'b0;
  logic stall = 1'b0;
  logic [15:0] o_rdata;
  logic o_ready, o_valid, i_ready;
  lfr_pkg::lfr_beat_t i_beat = '0;
  lfr_pkg::lfr_res_t o_res;
  int fail_count = 0;
  int check_count = 0;
  always #5 i_clk = ~i_clk;
  lfr_cell DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_valid(i_valid), .i_beat(i_beat), .o_ready(o_ready), .o_valid(o_valid),
    .o_res(o_res), .i_ready(i_ready));
  lfr_sink SNK (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(o_valid), .i_res(o_res), .o_ready(i_ready),
    .i_stall(stall));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    // read data stand for one cycle only; look mid-cycle
    @(negedge i_clk);
    chk(o_rdata, exp);
    @(posedge i_clk);
  endtask
  // valid stays up between beats; caller lowers it when done
  task automatic send(input lfr_pkg::lfr_beat_t b);
    logic ok;
    i_beat <= b;
    i_valid <= 1'b1;
    do begin
      @(negedge i_clk);
      ok = (o_ready === 1'b1);
      @(posedge i_clk);
    end while (!ok);
  endtask
  task automatic drain(input int n);
    i_valid <= 1'b0;
    repeat (300) if (SNK.got.size() < n) @(posedge i_clk);
    chk(SNK.got.size(), n);
  endtask
  task automatic t_regs();
    rdc(lfr_pkg::LFR_ADDR_MODE, 16'h0000);
    rdc(lfr_pkg::LFR_ADDR_TAP, lfr_pkg::LFR_TAP_RST);
    rdc(4'hc, 16'h0000);
    rdc(lfr_pkg::LFR_ADDR_STAT, {11'h000, lfr_pkg::LFR_BUF_EMPTY, 1'b1, 1'b0});
    wr(lfr_pkg::LFR_ADDR_STAT, 16'hffff);
    rdc(lfr_pkg::LFR_ADDR_STAT, {11'h000, lfr_pkg::LFR_BUF_EMPTY, 1'b1, 1'b0});
    wr(lfr_pkg::LFR_ADDR_MODE, 16'hffff);
    rdc(lfr_pkg::LFR_ADDR_MODE, 16'h03ff);
    wr(lfr_pkg::LFR_ADDR_MODE, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_logic();
    lfr_pkg::lfr_beat_t b;
    logic [15:0] f0 = 16'ha5c3;
    logic [15:0] f4 = 16'h6996;
    wr(4'h0, f0);
    wr(4'h4, f4);
    SNK.got.delete();
    for (int i = 0; i < 16; i++) begin
      b = '0;
      for (int k = 0; k < 8; k++) b.table_select_inputs[k] = i[3:0];
      b.we = 1'b1;
      b.wdata = 4'hf;
      b.wide_sel = i[0] ? 4'h8 : 4'h4;
      b.wide_in = i[1];
      send(b);
    end
    drain(16);
    for (int i = 0; i < 16; i++) begin
      chk(SNK.got[i].lut[0], f0[i]);
      chk(SNK.got[i].lut[4], f4[i]);
      chk(SNK.got[i].wide, i[0] ? i[1] : f4[i]);
    end
    $display("t_logic done");
  endtask
  task automatic t_ram();
    lfr_pkg::lfr_beat_t b [5];
    for (int i = 0; i < 5; i++) b[i] = '0;
    b[0].table_select_inputs[0] = 4'h5;
    b[0].we = 1'b1;
    b[0].wdata = 4'h1;
    b[1].table_select_inputs[1] = 4'h5;
    b[2].table_select_inputs[0] = 4'h5;
    b[3].table_select_inputs[0] = 4'h6;
    b[3].wdata = 4'h1;
    b[4].table_select_inputs[0] = 4'h6;
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0000);
    wr(lfr_pkg::LFR_ADDR_MODE, 16'h0105);
    SNK.got.delete();
    stall <= 1'b1;
    send(b[0]);
    send(b[1]);
    @(negedge i_clk);
    chk(o_ready, 1'b0);
    @(posedge i_clk);
    fork
      begin
        repeat (6) @(posedge i_clk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 2; i < 5; i++) send(b[i]);
    drain(5);
    chk(SNK.got[0].lut[0], 1'b0);
    chk(SNK.got[1].lut[0], 1'b1);
    chk(SNK.got[1].lut[1], 1'b1);
    chk(SNK.got[2].lut[0], 1'b1);
    chk(SNK.got[4].lut[0], 1'b0);
    $display("t_ram done");
  endtask
  // deep mode: bank picks the single table that takes the write
  task automatic t_deep();
    lfr_pkg::lfr_beat_t b;
    b = '0;
    b.table_select_inputs[0] = 4'h3;
    b.table_select_inputs[1] = 4'h3;
    b.we = 1'b1;
    b.wdata = 4'h3;
    b.bank = 2'h1;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(lfr_pkg::LFR_ADDR_MODE, 16'h0005);
    wr(lfr_pkg::LFR_ADDR_CTRL, 16'h0002);
    SNK.got.delete();
    send(b);
    drain(1);
    rdc(4'h0, 16'h0000);
    rdc(4'h1, 16'h0008);
    wr(lfr_pkg::LFR_ADDR_CTRL, 16'h0000);
    $display("t_deep done");
  endtask
  task automatic t_shift(input logic [15:0] m, t, c, input int k, input int d);
    lfr_pkg::lfr_beat_t b;
    for (int i = 0; i < 4; i++) wr(i[3:0], 16'h0000);
    wr(lfr_pkg::LFR_ADDR_MODE, m);
    wr(lfr_pkg::LFR_ADDR_TAP, t);
    wr(lfr_pkg::LFR_ADDR_CTRL, c);
    SNK.got.delete();
    for (int i = 0; i < d + 4; i++) begin
      b = '0;
      b.we = 1'b1;
      b.cascade_in = (i == 0) && c[0];
      b.wdata[0] = (i == 0) && !c[0];
      send(b);
    end
    drain(d + 4);
    for (int i = 0; i < d + 4; i++) begin
      chk(SNK.got[i].lut[k], i == d);
      chk(SNK.got[i].cascade_out, c[0] && i == d);
    end
    $display("t_shift delay %0d done", d);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_logic();
    t_ram();
    t_deep();
    t_shift(16'h0002, 16'h0000, 16'h0000, 0, 1);
    t_shift(16'h0002, 16'h000f, 16'h0000, 0, 16);
    t_shift(16'h00aa, 16'hf000, 16'h0001, 3, 64);
    tally_and_finish();
  end
endmodule
